// File: verilog/ext_bus_pkg.sv
// Package of timing constants and cycle kinds for the external memory bus sequencer
package ext_bus_pkg;

    // ****************************************************************
    // Machine cycle framing (one clock = one oscillator period)
    // ****************************************************************
    localparam int unsigned OSC_PERIOD_NS = 50;
    localparam int unsigned CORE_CLK_HZ = 20_000_000;
    localparam int unsigned CYCLE_LEN_NS = 12 * OSC_PERIOD_NS;
    localparam int unsigned CYCLE_LEN = (CYCLE_LEN_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] LAST_SLOT = 4'(CYCLE_LEN - 1);

    // ****************************************************************
    // Slot positions and window lengths within the machine cycle
    // ****************************************************************
    localparam logic [3:0] ADDR_SETUP_SLOT = 4'h0;
    localparam logic [3:0] LATCH_START = 4'h1;
    localparam logic [3:0] LATCH_LEN = 4'h2;
    localparam logic [3:0] FETCH_START = 4'h4;
    localparam logic [3:0] FETCH_LEN = 4'h3;
    localparam logic [3:0] XFER_START = 4'h6;
    localparam logic [3:0] XFER_LEN = 4'h6;
    localparam logic [3:0] PORT_SAMPLE_SLOT = 4'h9;
    localparam logic [3:0] PORT_UPDATE_SLOT = 4'hB;

    // ****************************************************************
    // Reset values and control bit positions
    // ****************************************************************
    localparam int unsigned LATCH_OFF_BIT = 0;
    localparam logic [7:0] PORT_RESET = 8'hFF;
    localparam logic [7:0] HIGH_ADDR_RESET = 8'hFF;

    typedef enum logic [1:0] {
        KIND_NONE,
        KIND_FETCH,
        KIND_READ,
        KIND_WRITE
    } cycle_kind_e;

endpackage

// File: verilog/strobe_window.sv
// Active-low strobe generator over a window of slots
`timescale 1ns/1ps
module strobe_window
    import ext_bus_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] slot,
    input wire logic enable,
    input wire logic [3:0] start_slot,
    input wire logic [3:0] width,
    input wire logic idle_level,
    output logic strobe
);
    logic [4:0] stop_slot;
    logic active_level;

    assign stop_slot = {1'b0, start_slot} + {1'b0, width};
    assign active_level = ~idle_level;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe <= 1'b1;
        end else if (enable && ({1'b0, slot} + 5'h01) == {1'b0, start_slot}) begin
            strobe <= active_level;
        end else if (({1'b0, slot} + 5'h01) == stop_slot
                     || (slot == LAST_SLOT && stop_slot > {1'b0, LAST_SLOT})) begin
            strobe <= idle_level;
        end else if (!enable && strobe == active_level && slot == LAST_SLOT) begin
            strobe <= idle_level;
        end
    end
endmodule

// File: verilog/ext_bus_seq.sv
// Machine-cycle sequencer for the multiplexed external memory bus
//
// Overview of operation
// R01 - Low address valid before latch pulse falls
// R02 - Low address held after latch pulse falls
// R03 - High address steady across fetch cycle
// R04 - Memory gives fetch byte within two periods
// R05 - Fetch access window is three periods
// R06 - Fetch byte captured before strobe rises
// R07 - Program memory floats bus within one period
// R08 - Data memory drives read within four periods
// R09 - Data read access time eight periods
// R10 - Data memory releases bus within two periods
// R11 - Write data valid before write strobe
// R12 - Write data held after write strobe
// R13 - Port inputs sampled at state five phase two
// R14 - Port outputs updated end of state six
// R15 - Port input stable before latch falls
// R16 - Latch high two, fetch strobe three periods
// R17 - Read/write strobe six periods, three after latch
// R18 - Latch off bit idles latch except externals
`timescale 1ns/1ps
module ext_bus_seq
    import ext_bus_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [1:0] req_kind,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic [7:0] fetch_byte,
    output logic fetch_valid,
    output logic [7:0] read_byte,
    output logic read_valid,
    input wire logic [7:0] auxiliary_control,
    input wire logic [7:0] port_wdata,
    input wire logic port_write,
    output logic [7:0] port_sampled,
    input wire logic [7:0] port_pins_in,
    output logic [7:0] port_pins_out,
    output logic address_latch,
    output logic program_fetch_strobe,
    output logic read_strobe_b,
    output logic write_strobe_b,
    input wire logic [7:0] low_byte_bus_in,
    output logic [7:0] low_byte_bus_out,
    output logic low_byte_bus_oe,
    output logic [7:0] high_addr_port
);
    // ****************************************************************
    // Slot counter and cycle kind
    // ****************************************************************
    logic [3:0] slot_q;
    cycle_kind_e kind_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [7:0] port_pend_q;
    logic port_pend_valid_q;
    logic ale_n;
    logic program_fetch_strobe_n;
    logic rd_n;
    logic wr_n;
    logic latch_en;
    logic latch_out;
    logic cycle_start;
    logic state5_phase2;
    logic state6_phase2;

    // ****************************************************************
    // Shared decodes
    // ****************************************************************
    // True for any cycle that touches external memory
    function automatic logic is_external(input logic [1:0] kind);
        begin
            is_external = cycle_kind_e'(kind) != KIND_NONE;
        end
    endfunction

    // Last slot of a strobe window, where the bus byte is captured
    function automatic logic [3:0] last_slot_of(input logic [3:0] start, input logic [3:0] len);
        begin
            last_slot_of = start + len - 4'h1;
        end
    endfunction

    // Slot counter wraps every machine cycle
    assign cycle_start = slot_q == LAST_SLOT;
    assign req_ready = cycle_start;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            slot_q <= 4'h0;
        end else if (slot_q == LAST_SLOT) begin
            slot_q <= 4'h0;
        end else begin
            slot_q <= slot_q + 4'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            kind_q <= KIND_NONE;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
        end else if (cycle_start) begin
            kind_q <= cycle_kind_e'(req_kind);
            addr_q <= req_addr;
            wdata_q <= req_wdata;
        end
    end

    // ****************************************************************
    // Strobe timing
    // ****************************************************************
    // Latch pulse idles when the off bit is set unless the cycle is external
    always_comb begin
        latch_en = !auxiliary_control[LATCH_OFF_BIT] || is_external(kind_q); // R18
    end

    strobe_window u_latch (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .slot(slot_q),
        .enable(latch_en),
        .start_slot(LATCH_START),
        .width(LATCH_LEN),
        .idle_level(1'b1),
        .strobe(ale_n)
    ); // R16
    assign latch_out = ~ale_n;

    // Program fetch strobe, low for the access window
    strobe_window u_fetch (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .slot(slot_q),
        .enable(kind_q == KIND_FETCH),
        .start_slot(FETCH_START),
        .width(FETCH_LEN),
        .idle_level(1'b1),
        .strobe(program_fetch_strobe_n)
    ); // R05 R16

    // Read strobe, low for the data access
    strobe_window u_read (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .slot(slot_q),
        .enable(kind_q == KIND_READ),
        .start_slot(XFER_START),
        .width(XFER_LEN),
        .idle_level(1'b1),
        .strobe(rd_n)
    ); // R09 R17

    // Write strobe, same window as read
    strobe_window u_write (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .slot(slot_q),
        .enable(kind_q == KIND_WRITE),
        .start_slot(XFER_START),
        .width(XFER_LEN),
        .idle_level(1'b1),
        .strobe(wr_n)
    ); // R17

    assign address_latch = latch_out;
    assign program_fetch_strobe = program_fetch_strobe_n;
    assign read_strobe_b = rd_n;
    assign write_strobe_b = wr_n;

    // ****************************************************************
    // Low byte bus drive
    // ****************************************************************
    // Address from slot 1 until one slot past latch fall
    // Write data stands from slot 4 through slot 0 of the next cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            low_byte_bus_out <= 8'h00;
            low_byte_bus_oe <= 1'b0;
        end else if (slot_q == ADDR_SETUP_SLOT) begin
            // Held write data leaves only one slot after the write strobe rises
            low_byte_bus_out <= addr_q[7:0]; // R01 R12
            low_byte_bus_oe <= is_external(kind_q);
        end else if (slot_q == LATCH_START + LATCH_LEN) begin
            low_byte_bus_out <= wdata_q; // R02 R11
            low_byte_bus_oe <= kind_q == KIND_WRITE;
        end
    end

    // High address held for the whole cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            high_addr_port <= HIGH_ADDR_RESET;
        end else if (cycle_start && is_external(req_kind)) begin
            high_addr_port <= req_addr[15:8]; // R03
        end
    end

    // ****************************************************************
    // Capture of fetched and read bytes
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fetch_byte <= 8'h00;
            fetch_valid <= 1'b0;
            read_byte <= 8'h00;
            read_valid <= 1'b0;
        end else begin
            fetch_valid <= 1'b0;
            read_valid <= 1'b0;
            // Fetch byte taken while the fetch strobe is still low
            if (kind_q == KIND_FETCH && slot_q == last_slot_of(FETCH_START, FETCH_LEN)) begin
                fetch_byte <= low_byte_bus_in; // R04 R06
                fetch_valid <= 1'b1;
            end
            // Read byte taken in the last slot of the read strobe
            if (kind_q == KIND_READ && slot_q == last_slot_of(XFER_START, XFER_LEN)) begin
                read_byte <= low_byte_bus_in; // R08
                read_valid <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Machine state phases
    // ****************************************************************
    // Phase markers for port sampling and port update
    assign state5_phase2 = slot_q == PORT_SAMPLE_SLOT;
    assign state6_phase2 = slot_q == PORT_UPDATE_SLOT;

    // ****************************************************************
    // Port sample and update
    // ****************************************************************
    // Input pins captured once per machine cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_sampled <= 8'h00;
        end else if (state5_phase2) begin
            port_sampled <= port_pins_in; // R13
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_pend_q <= PORT_RESET;
            port_pend_valid_q <= 1'b0;
            port_pins_out <= PORT_RESET;
        end else begin
            // Latest written value reaches the pins at the end of the cycle
            if (state6_phase2 && (port_pend_valid_q || port_write)) begin
                port_pins_out <= port_write ? port_wdata : port_pend_q; // R14
                port_pend_valid_q <= 1'b0;
            end else if (port_write) begin
                port_pend_q <= port_wdata;
                port_pend_valid_q <= 1'b1;
            end
        end
    end

endmodule

// File: test/ext_bus_assertions.sv
// Checker of bus cycle timing at the sequencer ports
`timescale 1ns/1ps
module ext_bus_assertions (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic req_ready,
    input wire logic [7:0] fetch_byte,
    input wire logic fetch_valid,
    input wire logic [7:0] port_sampled,
    input wire logic [7:0] port_pins_out,
    input wire logic address_latch,
    input wire logic program_fetch_strobe,
    input wire logic read_strobe_b,
    input wire logic write_strobe_b,
    input wire logic [7:0] low_byte_bus_in,
    input wire logic [7:0] low_byte_bus_out,
    input wire logic low_byte_bus_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence s_fetch3; !program_fetch_strobe[*3] ##1 program_fetch_strobe; endsequence
    sequence s_read6; !read_strobe_b[*6] ##1 read_strobe_b; endsequence
    a_latch_two_high: assert property ($rose(address_latch) |=>
        address_latch ##1 !address_latch) else $error("latch width");
    a_fetch_width: assert property ($fell(program_fetch_strobe) |-> s_fetch3)
        else $error("fetch strobe width");
    a_fetch_gap: assert property ($fell(program_fetch_strobe) |->
        $past(address_latch, 2) && !$past(address_latch)) else $error("fetch gap");
    a_read_width: assert property ($fell(read_strobe_b) |-> s_read6)
        else $error("read strobe width");
    a_strobe_gap: assert property ($fell(read_strobe_b) || $fell(write_strobe_b) |->
        $past(address_latch, 4) && !$past(address_latch, 3)) else $error("rw gap");
    a_addr_held: assert property ($fell(address_latch) && $past(low_byte_bus_oe, 2) |->
        low_byte_bus_oe && low_byte_bus_out == $past(low_byte_bus_out)
        && $past(low_byte_bus_out) == $past(low_byte_bus_out, 2))
        else $error("address not held");
    a_wdata_held: assert property ($fell(write_strobe_b) |->
        (low_byte_bus_oe && $stable(low_byte_bus_out))[*7]) else $error("write data");
    a_fetch_capture: assert property ($rose(program_fetch_strobe) |->
        fetch_valid && fetch_byte == $past(low_byte_bus_in)) else $error("fetch capture");
    a_port_sample: assert property ($changed(port_sampled) |=> req_ready)
        else $error("port sample slot");
    a_port_update: assert property ($changed(port_pins_out) |-> $past(req_ready))
        else $error("port update slot");
endmodule

// File: test/ext_mem_model.sv
// Behavioural program and data memory with address latch
`timescale 1ns/1ps
module ext_mem_model
    import ext_bus_pkg::*;
(
    input wire logic core_clk,
    input wire logic address_latch,
    input wire logic program_fetch_strobe,
    input wire logic read_strobe_b,
    input wire logic write_strobe_b,
    input wire logic [7:0] low_byte_bus_out,
    input wire logic low_byte_bus_oe,
    input wire logic [7:0] high_addr_port,
    input wire logic [2:0] dly,
    output logic [7:0] low_byte_bus_in
);
    logic [7:0] lat_q = 8'h00;
    logic [7:0] junk_q = 8'h00;
    logic [7:0] ram [256];
    int cnt = 0;
    always @(posedge core_clk) begin
        junk_q <= junk_q + 8'h3B;
        if (address_latch) lat_q <= low_byte_bus_out;
        if (!write_strobe_b) ram[lat_q] <= low_byte_bus_out;
        cnt <= (!program_fetch_strobe || !read_strobe_b) ? cnt + 1 : 0;
    end
    always_comb begin
        if (low_byte_bus_oe) low_byte_bus_in = low_byte_bus_out;
        else if (!program_fetch_strobe && cnt >= ((dly > 3'h2) ? 2 : dly))
            low_byte_bus_in = lat_q ^ high_addr_port;
        else if (!read_strobe_b && cnt >= dly) low_byte_bus_in = ram[lat_q];
        else low_byte_bus_in = junk_q;
    end
endmodule

// File: test/ext_bus_seq_bench.sv
// Self-checking bench of the external bus sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module ext_bus_seq_bench
    import ext_bus_pkg::*;
;
    logic core_clk = 0, rst_b = 0, port_write = 0, req_ready, fetch_valid, read_valid;
    logic [1:0] req_kind = 0;
    logic [15:0] req_addr = 0;
    logic [7:0] req_wdata = 0, auxiliary_control = 0, port_wdata = 0, port_pins_in = 0;
    logic [7:0] fetch_byte, read_byte, port_sampled, port_pins_out;
    logic [7:0] low_byte_bus_in, low_byte_bus_out, high_addr_port;
    logic address_latch, program_fetch_strobe, read_strobe_b, write_strobe_b, low_byte_bus_oe;
    logic [2:0] dly = 0;
    int bad_count = 0, cmp_count = 0, cyc = 0, n;
    ext_bus_seq u_dut (.core_clk, .rst_b, .req_kind, .req_addr, .req_wdata, .req_ready,
        .fetch_byte, .fetch_valid, .read_byte, .read_valid, .auxiliary_control, .port_wdata,
        .port_write, .port_sampled, .port_pins_in, .port_pins_out, .address_latch,
        .program_fetch_strobe, .read_strobe_b, .write_strobe_b, .low_byte_bus_in,
        .low_byte_bus_out, .low_byte_bus_oe, .high_addr_port);
    ext_mem_model u_mem (.core_clk, .address_latch, .program_fetch_strobe, .read_strobe_b,
        .write_strobe_b, .low_byte_bus_out, .low_byte_bus_oe, .high_addr_port, .dly,
        .low_byte_bus_in);
    always #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc > 2000) begin
            bad_count++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("bad %0d compared %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task issue(input logic [1:0] k, input logic [15:0] a, input logic [7:0] d);
        @(negedge core_clk);
        while (req_ready !== 1'b1) @(negedge core_clk);
        req_kind = k;
        req_addr = a;
        req_wdata = d;
        @(negedge core_clk);
        req_kind = KIND_NONE;
    endtask
    task t_write_read;
        for (int i = 0; i < 4; i++) issue(KIND_WRITE, 16'h0120 + 16'(i), 8'hC3 ^ 8'(i));
        dly = 3'h4;
        for (int i = 0; i < 4; i++) begin
            issue(KIND_READ, 16'h0120 + 16'(i), 8'h00);
            n = 0;
            while (read_valid !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
            `CHK(read_byte, 8'hC3 ^ 8'(i))
        end
    endtask
    task t_fetch;
        for (int d = 0; d < 3; d += 2) begin
            dly = 3'(d);
            issue(KIND_FETCH, 16'h5A3C + 16'(d), 8'h00);
            n = 0;
            while (fetch_valid !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
            `CHK(fetch_byte, 8'h5A ^ (8'h3C + 8'(d)))
            `CHK(high_addr_port, 8'h5A)
        end
    endtask
    task t_port;
        issue(KIND_NONE, 16'h0000, 8'h00);
        port_pins_in = 8'h96;
        port_wdata = 8'h4B;
        port_write = 1;
        @(negedge core_clk);
        port_write = 0;
        repeat (8) @(negedge core_clk);
        `CHK(port_pins_out, PORT_RESET)
        repeat (3) @(negedge core_clk);
        `CHK(port_pins_out, 8'h4B)
        `CHK(port_sampled, 8'h96)
    endtask
    task t_latch_off;
        auxiliary_control = 8'h01;
        issue(KIND_NONE, 16'h0000, 8'h00);
        n = 0;
        repeat (24) begin @(negedge core_clk); n += int'(address_latch); end
        `CHK(n, 0)
        issue(KIND_READ, 16'h0121, 8'h00);
        n = 0;
        repeat (11) begin @(negedge core_clk); n += int'(address_latch); end
        `CHK(n, 2)
        auxiliary_control = 8'h00;
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        rst_b = 1;
        t_write_read();
        t_fetch();
        t_port();
        t_latch_off();
        print_verdict();
    end
endmodule
bind ext_bus_seq ext_bus_assertions u_chk (.core_clk, .rst_b, .req_ready, .fetch_byte,
    .fetch_valid, .port_sampled, .port_pins_out, .address_latch, .program_fetch_strobe,
    .read_strobe_b, .write_strobe_b, .low_byte_bus_in, .low_byte_bus_out, .low_byte_bus_oe);
